// ===== hdl/indicator_map.svh
// register indices, field positions, reset values and timing constants
// for the indicator output block; included by the package only
`ifndef INDICATOR_MAP_SVH
`define INDICATOR_MAP_SVH

// register indices; byte address on the bus is four times the index
`define MODE_IDX      12'h450
`define OVR_IDX       12'h451
`define PINFN_IDX     12'h452

// reset values and writable-bit masks
`define MODE_RST      16'h2610
`define OVR_RST       16'h0000
`define PINFN_RST     3'h0
`define MODE_WMASK    16'h7fff
`define OVR_WMASK     16'h0fff

// field positions
`define BYPASS_BIT    14
`define BLINK_LSB     12
`define COMPL_LSB     9
`define OPT_W         4
`define OVR_W         3

// timing: clock rate in MHz, blink periods and activity stretch in ms
`define CLK_MHZ       50
`define BLINK_50_MS   50
`define BLINK_100_MS  100
`define BLINK_200_MS  200
`define BLINK_500_MS  500
`define STRETCH_MS    50

`endif

// ===== hdl/indicator_pkg.sv
// types shared by the indicator output block
// assumes indicator_map.svh is on the include path
`include "indicator_map.svh"

package indicator_pkg;

  // apb request from the master and answer from this slave
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  // status arriving from the transceiver core
  typedef struct packed {
    logic       link_up;
    logic       is_master;
    logic       tx_act;
    logic       rx_act;
    logic       mii_tx_err;
    logic       mii_rx_err;
    logic       prbs_err;
    logic       basic_status_read;
    logic       prbs_err_clear;
    logic [5:0] compl_sig;
  } ind_in_t;

  // per-indicator source codes
  typedef enum logic [3:0] {
    SRC_LINK       = 4'b0000,
    SRC_LINK_TXRX  = 4'b0001,
    SRC_LINK_TX    = 4'b0010,
    SRC_LINK_RX    = 4'b0011,
    SRC_MASTER     = 4'b0100,
    SRC_SLAVE      = 4'b0101,
    SRC_ACT_STR    = 4'b0110,
    SRC_LINK_LOST  = 4'b1001,
    SRC_PRBS_LATCH = 4'b1010,
    SRC_MII_ERR    = 4'b1011
  } src_t;

  // indicator-zero pin functions
  typedef enum logic [2:0] {
    PIN_NORMAL = 3'b000,
    PIN_COMPL  = 3'b101,
    PIN_ZERO   = 3'b110,
    PIN_ONE    = 3'b111
  } pin_fn_t;

  // whole state of the block
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] ovr;
    logic [2:0]  pin0_fn;
    logic [23:0] blink_cnt;
    logic        phase;
    logic [2:0]  act_seen;
    logic [23:0] act_cnt;
    logic [23:0] err_cnt;
    logic        link_q;
    logic        link_lost;
    logic        prbs_latch;
    logic [2:0]  ind;
    logic [31:0] prdata;
  } st_t;

endpackage

// ===== hdl/indicator_output_config.sv
// indicator output block: source select, blink, stretch, latches,
// override and polarity for three indicators, apb register slave
// assumes status inputs synchronous to pclk and a zero-wait apb master
//
// Contract
// - the two-bit blink field picks a 50, 100, 200 or 500 ms period.
// - codes 0000..0011 give link, or link with blink on txrx/tx/rx.
// - codes 0100 and 0101 light on link as master or as slave.
// - code 0110 shows combined activity stretched to stay visible.
// - code 1001 latches link loss until the basic status read.
// - code 1010 latches a prbs error until its clear strobe.
// - code 1011 shows mii transmit or receive errors, stretched.
// - the mode register resets to 0x2610.
// - an override enable drives its override value instead.
// - a three-bit selector routes one compliance signal to pin zero.
// - pin-zero function 000 is the indicator, 101 the compliance one.
`timescale 1ns/1ps

module indicator_output_config
  import indicator_pkg::*;
#(
  parameter int unsigned BLINK_50_CYC  = `BLINK_50_MS  * 1000 * `CLK_MHZ,
  parameter int unsigned BLINK_100_CYC = `BLINK_100_MS * 1000 * `CLK_MHZ,
  parameter int unsigned BLINK_200_CYC = `BLINK_200_MS * 1000 * `CLK_MHZ,
  parameter int unsigned BLINK_500_CYC = `BLINK_500_MS * 1000 * `CLK_MHZ,
  parameter int unsigned STRETCH_CYC   = `STRETCH_MS   * 1000 * `CLK_MHZ
) (
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire apb_req_t apb_req,
  output apb_rsp_t      apb_rsp,
  input  wire ind_in_t  status,
  output logic [2:0]    indicator
);

  localparam st_t ST_RST = '{
    mode: `MODE_RST, ovr: `OVR_RST, pin0_fn: `PINFN_RST,
    default: '0};

  st_t         st;
  st_t         next_st;
  logic [23:0] half;
  logic        setup;
  logic        access;
  logic [1:0]  hit;
  logic        act_raw;
  logic        err_raw;
  logic        act_s;
  logic        err_s;
  logic        lvl;

  // register decode: 0 mode, 1 override, 2 pin function, 3 unmapped
  function automatic logic [1:0] reg_hit(input logic [15:0] a);
    logic [1:0] r;
    r = 2'h3;
    if (a == {2'b00, `MODE_IDX, 2'b00})  r = 2'h0;
    if (a == {2'b00, `OVR_IDX, 2'b00})   r = 2'h1;
    if (a == {2'b00, `PINFN_IDX, 2'b00}) r = 2'h2;
    return r;
  endfunction

  // level of one indicator for its source code, before override
  function automatic logic src_level(input logic [3:0] code,
                                     input ind_in_t    in,
                                     input st_t        s,
                                     input logic       a_s,
                                     input logic       e_s);
    logic r;
    r = 1'b0;
    case (src_t'(code))
      SRC_LINK:       r = in.link_up;
      SRC_LINK_TXRX:  r = in.link_up & ~(s.act_seen[0] & s.phase);
      SRC_LINK_TX:    r = in.link_up & ~(s.act_seen[1] & s.phase);
      SRC_LINK_RX:    r = in.link_up & ~(s.act_seen[2] & s.phase);
      SRC_MASTER:     r = in.link_up & in.is_master;
      SRC_SLAVE:      r = in.link_up & ~in.is_master;
      SRC_ACT_STR:    r = a_s;
      SRC_LINK_LOST:  r = s.link_lost;
      SRC_PRBS_LATCH: r = s.prbs_latch;
      SRC_MII_ERR:    r = e_s;
      default:        r = 1'b0; // reserved codes stay dark
    endcase
    return r;
  endfunction

  // apb answer: zero wait states, read data captured in setup
  assign setup            = apb_req.psel & ~apb_req.penable;
  assign access           = apb_req.psel & apb_req.penable;
  assign hit              = reg_hit(apb_req.paddr);
  assign apb_rsp.pready   = 1'b1;
  assign apb_rsp.pslverr  = access & (hit == 2'h3);
  assign apb_rsp.prdata   = st.prdata;
  assign indicator        = st.ind;

  assign act_raw = status.tx_act | status.rx_act;
  assign err_raw = status.mii_tx_err | status.mii_rx_err;

  // raw event also counts as stretched so the first cycle is not lost
  assign act_s = st.mode[`BYPASS_BIT] ? act_raw
               : (act_raw | (st.act_cnt != 24'h0));
  assign err_s = st.mode[`BYPASS_BIT] ? err_raw
               : (err_raw | (st.err_cnt != 24'h0));

  // one toggle of the blink phase every half of the selected period
  always_comb begin
    case (st.mode[`BLINK_LSB +: 2])
      2'b00:   half = 24'(BLINK_50_CYC / 2);
      2'b01:   half = 24'(BLINK_100_CYC / 2);
      2'b10:   half = 24'(BLINK_200_CYC / 2);
      default: half = 24'(BLINK_500_CYC / 2);
    endcase
  end

  // next-state logic for registers, timers, latches and outputs
  always_comb begin
    next_st = st;
    lvl     = 1'b0;

    // register writes take effect in the access phase
    if (access && apb_req.pwrite) begin
      case (hit)
        2'h0:    next_st.mode = apb_req.pwdata[15:0] & `MODE_WMASK;
        2'h1:    next_st.ovr  = apb_req.pwdata[15:0] & `OVR_WMASK;
        2'h2:    next_st.pin0_fn = apb_req.pwdata[2:0];
        default: next_st.mode = st.mode;
      endcase
    end
    if (setup) begin
      case (hit)
        2'h0:    next_st.prdata = {16'h0000, st.mode};
        2'h1:    next_st.prdata = {16'h0000, st.ovr};
        2'h2:    next_st.prdata = {29'h0, st.pin0_fn};
        default: next_st.prdata = 32'h0;
      endcase
    end

    // a shorter rate takes effect at once thanks to the >= compare
    if (st.blink_cnt >= half - 24'h1) begin
      next_st.blink_cnt = 24'h0;
      next_st.phase     = ~st.phase;
      next_st.act_seen  = 3'b000;
    end else begin
      next_st.blink_cnt = st.blink_cnt + 24'h1;
    end
    // activity set after the clear, so an event at the toggle survives
    next_st.act_seen = next_st.act_seen |
      {status.rx_act, status.tx_act, act_raw};

    // stretch timers reload on every event
    if (act_raw)
      next_st.act_cnt = 24'(STRETCH_CYC);
    else if (st.act_cnt != 24'h0)
      next_st.act_cnt = st.act_cnt - 24'h1;
    if (err_raw)
      next_st.err_cnt = 24'(STRETCH_CYC);
    else if (st.err_cnt != 24'h0)
      next_st.err_cnt = st.err_cnt - 24'h1;

    // sticky latches: a new event wins over a clear in the same cycle
    next_st.link_q = status.link_up;
    if (status.basic_status_read)
      next_st.link_lost = 1'b0;
    if (st.link_q && !status.link_up)
      next_st.link_lost = 1'b1;
    if (status.prbs_err_clear)
      next_st.prbs_latch = 1'b0;
    if (status.prbs_err)
      next_st.prbs_latch = 1'b1;

    // per indicator: source, override, then polarity
    for (int i = 0; i < 3; i++) begin
      lvl = src_level(st.mode[i*`OPT_W +: `OPT_W], status, st,
                      act_s, err_s);
      if (st.ovr[i*`OVR_W + 2])
        lvl = st.ovr[i*`OVR_W + 1];
      next_st.ind[i] = lvl ^ st.ovr[i*`OVR_W];
    end

    // indicator zero pin function; other codes drive indicator zero low
    case (pin_fn_t'(st.pin0_fn))
      PIN_NORMAL: next_st.ind[0] = next_st.ind[0];
      PIN_COMPL: begin
        if (st.ovr[`COMPL_LSB +: 3] < 3'h6)
          next_st.ind[0] =
            status.compl_sig[st.ovr[`COMPL_LSB +: 3]];
        else
          next_st.ind[0] = 1'b0;
      end
      PIN_ONE:    next_st.ind[0] = 1'b1;
      default:    next_st.ind[0] = 1'b0;
    endcase
  end

  // single state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      st <= ST_RST;
    else
      st <= next_st;
  end

  // ---- assertions ----
  sequence s_link_drop;
    st.link_q && !status.link_up;
  endsequence

  sequence s_plain1;
    !st.ovr[5] && !st.ovr[3];
  endsequence

  property p_blink_rate;
    @(posedge pclk) disable iff (!presetn)
    (st.phase != $past(st.phase)) |->
      ($past(st.blink_cnt) >= $past(half) - 24'h1);
  endproperty
  a_blink_rate: assert property (p_blink_rate)
    else $error("blink phase toggled early");

  property p_link_only;
    @(posedge pclk) disable iff (!presetn)
    (s_plain1 and (st.mode[7:4] == 4'h0)) |=>
      (indicator[1] == $past(status.link_up));
  endproperty
  a_link_only: assert property (p_link_only)
    else $error("link indicator does not follow link");

  property p_master;
    @(posedge pclk) disable iff (!presetn)
    (s_plain1 and (st.mode[7:4] == 4'h4)) |=>
      (indicator[1] == $past(status.link_up && status.is_master));
  endproperty
  a_master: assert property (p_master)
    else $error("master indicator wrong");

  // the drop must set the latch outright, not only keep it once set
  property p_link_lost;
    @(posedge pclk) disable iff (!presetn)
    s_link_drop |=> st.link_lost;
  endproperty
  a_link_lost: assert property (p_link_lost)
    else $error("link loss not latched");

  sequence s_loss_kept;
    st.link_lost && !status.basic_status_read;
  endsequence

  // only the basic status read may clear a latched loss
  property p_link_held;
    @(posedge pclk) disable iff (!presetn)
    s_loss_kept |=> st.link_lost;
  endproperty
  a_link_held: assert property (p_link_held)
    else $error("link loss not held");

  property p_prbs_clear;
    @(posedge pclk) disable iff (!presetn)
    (status.prbs_err_clear && !status.prbs_err) |=> !st.prbs_latch;
  endproperty
  a_prbs_clear: assert property (p_prbs_clear)
    else $error("prbs latch not cleared");

  property p_prbs_set;
    @(posedge pclk) disable iff (!presetn)
    status.prbs_err |=> st.prbs_latch;
  endproperty
  a_prbs_set: assert property (p_prbs_set)
    else $error("prbs error lost");

  property p_mode_reset;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (st.mode == 16'h2610);
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("mode reset value wrong");

  property p_override;
    @(posedge pclk) disable iff (!presetn)
    (st.ovr[2] && st.pin0_fn == 3'b000) |=>
      (indicator[0] == $past(st.ovr[1] ^ st.ovr[0]));
  endproperty
  a_override: assert property (p_override)
    else $error("override value not driven");

  property p_compl;
    @(posedge pclk) disable iff (!presetn)
    (st.pin0_fn == 3'b101 && st.ovr[11:9] == 3'b011) |=>
      (indicator[0] == $past(status.compl_sig[3]));
  endproperty
  a_compl: assert property (p_compl)
    else $error("compliance signal not routed");

  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
    (st.mode[14] && st.mode[11:8] == 4'h6 && st.ovr[8:6] == 3'b000) |=>
      (indicator[2] == $past(act_raw));
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass does not follow raw activity");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
    (st.ovr[5] && st.ovr[3]) |=> (indicator[1] == !$past(st.ovr[4]));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("polarity not applied");

endmodule // indicator_output_config

// ===== bench/tb_indicator_output_config.sv
// testbench for the indicator output block: apb register tasks and
// status stimulus; assumes the slave answers within 49 access cycles
`timescale 1ns/1ps

module tb_indicator_output_config
  import indicator_pkg::*;
;
  localparam int str_cyc = 20;
  localparam int per[4] = '{40, 80, 160, 400};
  // bit positions of event inputs inside the status struct
  localparam int tx_b  = 12;
  localparam int rx_b  = 11;
  localparam int txe_b = 10;
  localparam int rxe_b = 9;
  localparam int prb_b = 8;
  localparam int bsr_b = 7;
  localparam int clr_b = 6;

  logic        pclk;
  logic        presetn;
  apb_req_t    req;
  apb_rsp_t    rsp;
  ind_in_t     st;
  logic [2:0]  ind;
  logic [2:0]  ind_pin;
  int          miscompares;
  int          checked;
  int          k;
  logic [31:0] rd;
  logic        err;

  indicator_output_config #(
    .BLINK_50_CYC  (40),
    .BLINK_100_CYC (80),
    .BLINK_200_CYC (160),
    .BLINK_500_CYC (400),
    .STRETCH_CYC   (str_cyc)
  ) i_indicator_output_config (
    .pclk      (pclk),
    .presetn   (presetn),
    .apb_req   (req),
    .apb_rsp   (rsp),
    .status    (st),
    .indicator (ind_pin)
  );

  // 50 MHz clock
  always #10 pclk = ~pclk;

  // settled copy of the indicators taken mid-cycle, so a check made at
  // a rising edge sees the value launched at the edge before, no race
  always @(negedge pclk) ind <= ind_pin;

  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask

  task finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task end_test(input string n);
    $display("test %s ended, %0d mismatches so far", n, miscompares);
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:wr, paddr:a, pwdata:d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("mismatch at %0t: no pready", $time);
      finish_test();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdchk(input logic [15:0] a, input logic [31:0] e, input logic ee,
             input string w);
    xfer(1'b0, a, 32'h0);
    chk(rd, e, w);
    chk({31'h0, err}, {31'h0, ee}, w);
  endtask

  task ichk(input int b, input logic e, input string w);
    chk({31'h0, ind[b]}, {31'h0, e}, w);
  endtask

  task pulse(input int pos);
    @(posedge pclk);
    st[pos] <= 1'b1;
    @(posedge pclk);
    st[pos] <= 1'b0;
  endtask

  // count dark cycles of one indicator over a window
  task dark(input int b, input int n);
    k = 0;
    repeat (n) begin
      @(posedge pclk);
      if (ind[b] === 1'b0) k++;
    end
  endtask

  // watchdog so a hang still reaches the verdict
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    $display("mismatch at %0t: run too long", $time);
    finish_test();
  end

  initial begin
    logic [15:0] ov[4];
    logic [2:0]  oe[4];
    ov = '{16'h0006, 16'h0007, 16'h0049, 16'h01a8};
    oe = '{3'b001, 3'b000, 3'b111, 3'b110};
    pclk = 1'b0;
    presetn = 1'b0;
    req = '0;
    st = '0;
    miscompares = 0;
    checked = 0;
    cyc(8);
    presetn <= 1'b1;
    // reset values, masks and an unmapped place
    rdchk(16'h1140, 32'h2610, 1'b0, "mode reset");
    rdchk(16'h1144, 32'h0, 1'b0, "ovr reset");
    rdchk(16'h1148, 32'h0, 1'b0, "pin reset");
    wr(16'h114c, 32'hffff);
    rdchk(16'h114c, 32'h0, 1'b1, "unmapped");
    // every source code written here is a defined one
    wr(16'h1140, 32'hfffffbab);
    rdchk(16'h1140, 32'h7bab, 1'b0, "mode mask");
    wr(16'h1144, 32'hffffffff);
    rdchk(16'h1144, 32'h0fff, 1'b0, "ovr mask");
    wr(16'h1144, 32'h0);
    end_test("registers");
    // link, master and slave codes
    wr(16'h1140, 32'h0540);
    @(posedge pclk);
    st.link_up <= 1'b1;
    st.is_master <= 1'b1;
    cyc(3);
    chk({29'h0, ind}, 32'h3, "master");
    st.is_master <= 1'b0;
    cyc(3);
    chk({29'h0, ind}, 32'h5, "slave");
    st.link_up <= 1'b0;
    cyc(3);
    chk({29'h0, ind}, 32'h0, "no link");
    end_test("roles");
    // override value and polarity, polarity also on overrides
    for (int i = 0; i < 4; i++) begin
      wr(16'h1144, {16'h0, ov[i]});
      cyc(3);
      chk({29'h0, ind}, {29'h0, oe[i]}, "override");
    end
    wr(16'h1144, 32'h0);
    // plain link on indicator one, master on zero, slave on two
    wr(16'h1140, 32'h0504);
    st.link_up <= 1'b1;
    st.is_master <= 1'b1;
    cyc(3);
    chk({29'h0, ind}, 32'h3, "link on one");
    end_test("override");
    // link-loss and error latches
    wr(16'h1140, 32'h06a9);
    @(posedge pclk);
    st.link_up <= 1'b1;
    pulse(bsr_b);
    cyc(3);
    ichk(0, 1'b0, "loss clear");
    st.link_up <= 1'b0;
    cyc(3);
    ichk(0, 1'b1, "loss set");
    st.link_up <= 1'b1;
    cyc(5);
    ichk(0, 1'b1, "loss held");
    pulse(bsr_b);
    cyc(3);
    ichk(0, 1'b0, "loss read");
    pulse(prb_b);
    cyc(10);
    ichk(1, 1'b1, "prbs held");
    pulse(clr_b);
    cyc(3);
    ichk(1, 1'b0, "prbs clear");
    end_test("latches");
    // stretched activity and mii errors, then stretch bypassed
    wr(16'h1140, 32'h06b0);
    pulse(tx_b);
    pulse(rxe_b);
    cyc(10);
    ichk(2, 1'b1, "act stretch");
    ichk(1, 1'b1, "err stretch");
    cyc(str_cyc + 10);
    ichk(2, 1'b0, "act end");
    ichk(1, 1'b0, "err end");
    wr(16'h1140, 32'h46b0);
    pulse(rx_b);
    cyc(1);
    ichk(2, 1'b1, "raw act");
    cyc(2);
    ichk(2, 1'b0, "bypass act");
    pulse(txe_b);
    cyc(3);
    ichk(1, 1'b0, "bypass err");
    end_test("stretch");
    // compliance signal routed to indicator zero
    wr(16'h1148, 32'h5);
    for (int s = 0; s < 6; s++) begin
      wr(16'h1144, 32'(s) << 9);
      st.compl_sig <= 6'h01 << s;
      cyc(3);
      ichk(0, 1'b1, "compl on");
      st.compl_sig <= ~(6'h01 << s);
      cyc(3);
      ichk(0, 1'b0, "compl off");
    end
    wr(16'h1148, 32'h0);
    wr(16'h1144, 32'h0);
    wr(16'h1140, 32'h0610);
    cyc(3);
    ichk(0, 1'b1, "normal fn");
    end_test("compliance");
    // blink periods under continuous transmit activity
    st.tx_act <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr(16'h1140, 32'h0611 | (32'(r) << 12));
      cyc(per[r]);
      dark(0, 2 * per[r]);
      chk(32'(k >= per[r] - 3 && k <= per[r] + 3), 32'h1, "blink");
    end
    wr(16'h1140, 32'h0612);
    cyc(per[0]);
    dark(0, 2 * per[0]);
    chk(32'(k >= per[0] - 3 && k <= per[0] + 3), 32'h1, "tx blink");
    wr(16'h1140, 32'h0613);
    cyc(per[0]);
    dark(0, 2 * per[0]);
    chk(32'(k), 32'h0, "rx only");
    end_test("blink");
    finish_test();
  end
endmodule // tb_indicator_output_config
